//--- common/msc_pkg.sv
package msc_pkg;

    // ========================================
    // Clock and timing
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned BOOT_WINDOW_MS = 500;
    localparam int unsigned FACTORY_HOLD_S = 10;
    localparam int unsigned DEBOUNCE_US = 1000;
    localparam int unsigned FLASH_MS = 50;
    // Millisecond tick divider
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
    localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / 1000000) * DEBOUNCE_US;
    localparam int unsigned FACTORY_HOLD_MS = FACTORY_HOLD_S * 1000;
    localparam int unsigned SLEEP_CLK_HZ_X1000 = 32768;

    localparam int MS_W = 16;
    localparam int TICK_W = 16;

    // ========================================
    // Status codes from the host logic
    typedef enum logic [1:0] {
        MSC_ST_IDLE,
        MSC_ST_CONNECTING,
        MSC_ST_CONNECTED
    } msc_link_e;

    // DSR pin function selection
    typedef enum logic [1:0] {
        MSC_DSR_OFF,
        MSC_DSR_CMD,
        MSC_DSR_DISC,
        MSC_DSR_CONNTGL
    } msc_dsr_e;

    // Boot outcome
    typedef enum logic [1:0] {
        MSC_BOOT_NORMAL,
        MSC_BOOT_SERIAL_DEF,
        MSC_BOOT_LOADER,
        MSC_BOOT_FACTORY
    } msc_boot_e;

endpackage : msc_pkg

//--- core/msc_ms_tick.sv
`timescale 1ns/1ns
module msc_ms_tick
    import msc_pkg::*;
#(
    parameter int unsigned PERIOD = MS_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    output logic tick
);

    // ========================================
    // Divider giving a one-cycle enable pulse
    logic [TICK_W-1:0] cnt_r;
    logic [TICK_W-1:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == TICK_W'(PERIOD - 1)) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule : msc_ms_tick

//--- core/msc_status_io.sv
`timescale 1ns/1ns
module msc_status_io
    import msc_pkg::*;
#(
    parameter int unsigned MS_PERIOD = MS_CYCLES,
    parameter int unsigned BOOT_MS = BOOT_WINDOW_MS,
    parameter int unsigned HOLD_MS = FACTORY_HOLD_MS,
    parameter int unsigned FLASH_PERIOD_MS = FLASH_MS,
    parameter int unsigned DEB_CYCLES = DEBOUNCE_CYCLES
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic RESET_PIN_N_IN,
    input wire logic SWITCH_CONNECT_N,
    input wire logic SWITCH_SERIAL_N,
    input wire logic DSR_N,
    input wire logic SLOW_SLEEP_CLOCK_IN,
    input wire logic CMD_MODE,
    input wire msc_link_e LINK_STATE,
    input wire logic DATA_ACTIVITY,
    input wire logic RESET_CMD,
    input wire msc_dsr_e DSR_FUNC,
    input wire logic DTR_AS_GPIO,
    input wire logic DTR_GPIO_VALUE,
    input wire logic DTR_READY,
    output logic RED_N,
    output logic GREEN_N,
    output logic GREEN_OE_N,
    output logic BLUE_N,
    output logic DTR_N,
    output logic HW_REBOOT,
    output logic SW_REBOOT,
    output logic BOOT_DONE,
    output msc_boot_e BOOT_ACTION,
    output logic SERIAL_DEFAULTS,
    output logic LOADER_MODE,
    output logic FACTORY_RESTORE,
    output logic CONNECT_REQ,
    output logic DSR_CMD_REQ,
    output logic DSR_DISC_REQ,
    output logic DSR_CONNTGL_REQ,
    output logic SLEEP_CLK_PRESENT
);

    // ========================================
    // Input conditioning
    logic ms_tick;
    logic conn_lvl;
    logic ser_lvl;
    logic dsr_lvl;
    logic rst_meta_r;
    logic rst_sync_r;
    logic slp_meta_r;
    logic slp_sync_r;
    logic slp_prev_r;

    msc_ms_tick #(.PERIOD(MS_PERIOD)) u_tick (
        .clk(CLK),
        .resetn(RESETN),
        .tick(ms_tick)
    );

    msc_sync_deb #(.STABLE_CYCLES(DEB_CYCLES), .RESET_LEVEL(1'b1)) u_deb_conn (
        .clk(CLK),
        .resetn(RESETN),
        .pin_in(SWITCH_CONNECT_N),
        .level_out(conn_lvl)
    );

    msc_sync_deb #(.STABLE_CYCLES(DEB_CYCLES), .RESET_LEVEL(1'b1)) u_deb_ser (
        .clk(CLK),
        .resetn(RESETN),
        .pin_in(SWITCH_SERIAL_N),
        .level_out(ser_lvl)
    );

    msc_sync_deb #(.STABLE_CYCLES(DEB_CYCLES), .RESET_LEVEL(1'b1)) u_deb_dsr (
        .clk(CLK),
        .resetn(RESETN),
        .pin_in(DSR_N),
        .level_out(dsr_lvl)
    );

    // ========================================
    // Boot sequencer
    typedef enum logic [2:0] {
        MSC_BS_WINDOW,
        MSC_BS_HOLD,
        MSC_BS_RUN
    } msc_bseq_e;

    msc_bseq_e bs_r;
    msc_bseq_e bs_nxt;
    logic [MS_W-1:0] ms_r;
    logic [MS_W-1:0] ms_nxt;
    msc_boot_e act_r;
    msc_boot_e act_nxt;
    logic done_r;
    logic done_nxt;
    logic both_low;

    assign both_low = !conn_lvl && !ser_lvl;

    always_comb begin
        bs_nxt = bs_r;
        ms_nxt = ms_r;
        act_nxt = act_r;
        done_nxt = done_r;
        if (ms_tick && ms_r != 16'hffff) begin
            ms_nxt = ms_r + 16'h0001;
        end
        unique case (bs_r)
            MSC_BS_WINDOW: begin
                // Only the 500ms window may pick serial defaults from the serial switch
                if (ms_tick && ms_r == MS_W'(BOOT_MS - 1)) begin
                    if (both_low) begin
                        bs_nxt = MSC_BS_HOLD;
                        act_nxt = MSC_BOOT_LOADER;
                    end else begin
                        bs_nxt = MSC_BS_RUN;
                        done_nxt = 1'b1;
                        act_nxt = !ser_lvl ? MSC_BOOT_SERIAL_DEF : MSC_BOOT_NORMAL;
                    end
                end
            end
            MSC_BS_HOLD: begin
                if (!both_low) begin
                    bs_nxt = MSC_BS_RUN;
                    done_nxt = 1'b1;
                end else if (ms_tick && ms_r == MS_W'(HOLD_MS - 1)) begin
                    bs_nxt = MSC_BS_RUN;
                    done_nxt = 1'b1;
                    act_nxt = MSC_BOOT_FACTORY;
                end
            end
            MSC_BS_RUN: begin
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            bs_r <= MSC_BS_WINDOW;
            ms_r <= '0;
            act_r <= MSC_BOOT_NORMAL;
            done_r <= 1'b0;
        end else begin
            bs_r <= bs_nxt;
            ms_r <= ms_nxt;
            act_r <= act_nxt;
            done_r <= done_nxt;
        end
    end

    // ========================================
    // Status colours and flashing
    logic [7:0] fl_cnt_r;
    logic [7:0] fl_cnt_nxt;
    logic fl_ph_r;
    logic fl_ph_nxt;
    logic act_seen_r;
    logic act_seen_nxt;
    logic g_nxt;
    logic b_nxt;
    logic r_nxt;
    logic red_r;
    logic green_r;
    logic green_oe_r;
    logic blue_r;
    logic linked;

    assign linked = (LINK_STATE == MSC_ST_CONNECTING) || (LINK_STATE == MSC_ST_CONNECTED);

    always_comb begin
        fl_cnt_nxt = fl_cnt_r;
        fl_ph_nxt = fl_ph_r;
        // Activity latched so a one-cycle burst still gives a visible blink
        act_seen_nxt = act_seen_r || DATA_ACTIVITY;
        if (ms_tick) begin
            if (fl_cnt_r == 8'(FLASH_PERIOD_MS - 1)) begin
                fl_cnt_nxt = '0;
                fl_ph_nxt = act_seen_r ? !fl_ph_r : 1'b0;
                act_seen_nxt = DATA_ACTIVITY;
            end else begin
                fl_cnt_nxt = fl_cnt_r + 8'h01;
            end
        end
        unique case (LINK_STATE)
            MSC_ST_CONNECTING: {g_nxt, b_nxt, r_nxt} = 3'b100;
            MSC_ST_CONNECTED: {g_nxt, b_nxt, r_nxt} = 3'b101;
            default: {g_nxt, b_nxt, r_nxt} = CMD_MODE ? 3'b010 : 3'b011;
        endcase
        if (linked && fl_ph_r) begin
            {g_nxt, b_nxt, r_nxt} = 3'b111;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            fl_cnt_r <= '0;
            fl_ph_r <= 1'b0;
            act_seen_r <= 1'b0;
            red_r <= 1'b1;
            green_r <= 1'b1;
            green_oe_r <= 1'b1;
            blue_r <= 1'b1;
        end else begin
            fl_cnt_r <= fl_cnt_nxt;
            fl_ph_r <= fl_ph_nxt;
            act_seen_r <= act_seen_nxt;
            red_r <= r_nxt;
            blue_r <= b_nxt;
            green_r <= g_nxt;
            // Shared pin stays an input while the switches still decide the boot
            green_oe_r <= !done_nxt;
        end
    end

    // ========================================
    // Control pins, reboot and sleep clock
    logic dsr_prev_r;
    logic conn_req_r;
    logic dsr_cmd_r;
    logic dsr_disc_r;
    logic dsr_tgl_r;
    logic dtr_r;
    logic hw_rb_r;
    logic sw_rb_r;
    logic slp_ok_r;
    logic [MS_W-1:0] slp_age_r;
    logic dsr_fall;
    logic [MS_W-1:0] slp_age_nxt;

    assign dsr_fall = dsr_prev_r && !dsr_lvl;
    assign slp_age_nxt = (slp_sync_r != slp_prev_r) ? '0 :
        (ms_tick && slp_age_r != 16'hffff) ? slp_age_r + 16'h0001 : slp_age_r;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= 1'b1;
            slp_meta_r <= 1'b0;
            slp_sync_r <= 1'b0;
            slp_prev_r <= 1'b0;
            slp_age_r <= 16'hffff;
            slp_ok_r <= 1'b0;
            dsr_prev_r <= 1'b1;
            conn_req_r <= 1'b0;
            dsr_cmd_r <= 1'b0;
            dsr_disc_r <= 1'b0;
            dsr_tgl_r <= 1'b0;
            dtr_r <= 1'b1;
            hw_rb_r <= 1'b0;
            sw_rb_r <= 1'b0;
        end else begin
            rst_meta_r <= RESET_PIN_N_IN;
            rst_sync_r <= rst_meta_r;
            hw_rb_r <= !rst_sync_r;
            sw_rb_r <= RESET_CMD;
            slp_meta_r <= SLOW_SLEEP_CLOCK_IN;
            slp_sync_r <= slp_meta_r;
            slp_prev_r <= slp_sync_r;
            slp_age_r <= slp_age_nxt;
            // A slow clock edge within 2 ms counts as present
            slp_ok_r <= slp_age_nxt < 16'h0002;
            dsr_prev_r <= dsr_lvl;
            conn_req_r <= done_r && !conn_lvl;
            dsr_cmd_r <= dsr_fall && DSR_FUNC == MSC_DSR_CMD;
            dsr_disc_r <= dsr_fall && DSR_FUNC == MSC_DSR_DISC;
            dsr_tgl_r <= dsr_fall && DSR_FUNC == MSC_DSR_CONNTGL;
            dtr_r <= DTR_AS_GPIO ? DTR_GPIO_VALUE : !DTR_READY;
        end
    end

    // ========================================
    // Outputs
    assign RED_N = red_r;
    assign GREEN_N = green_r;
    assign GREEN_OE_N = green_oe_r;
    assign BLUE_N = blue_r;
    assign DTR_N = dtr_r;
    assign HW_REBOOT = hw_rb_r;
    assign SW_REBOOT = sw_rb_r;
    assign BOOT_DONE = done_r;
    assign BOOT_ACTION = act_r;
    assign SERIAL_DEFAULTS = done_r && act_r == MSC_BOOT_SERIAL_DEF;
    assign LOADER_MODE = bs_r == MSC_BS_HOLD;
    assign FACTORY_RESTORE = done_r && act_r == MSC_BOOT_FACTORY;
    assign CONNECT_REQ = conn_req_r;
    assign DSR_CMD_REQ = dsr_cmd_r;
    assign DSR_DISC_REQ = dsr_disc_r;
    assign DSR_CONNTGL_REQ = dsr_tgl_r;
    assign SLEEP_CLK_PRESENT = slp_ok_r;

    // ========================================
    // Checks
    sequence s_boot_end;
        ms_tick && bs_r == MSC_BS_WINDOW && ms_r == MS_W'(BOOT_MS - 1);
    endsequence

    AST_SER_DEFAULT: assert property (@(posedge CLK) disable iff (!RESETN)
        s_boot_end and (ser_lvl == 1'b0 && conn_lvl == 1'b1) |=> SERIAL_DEFAULTS)
        else $error("Serial defaults not chosen");
    AST_LOADER: assert property (@(posedge CLK) disable iff (!RESETN)
        s_boot_end and both_low |=> LOADER_MODE && !BOOT_DONE)
        else $error("Bootloader not entered");
    AST_NO_LATE_SER: assert property (@(posedge CLK) disable iff (!RESETN)
        bs_r == MSC_BS_RUN |=> $stable(act_r))
        else $error("Boot choice changed after window");
    AST_GREEN_OE: assert property (@(posedge CLK) disable iff (!RESETN)
        !BOOT_DONE |-> GREEN_OE_N)
        else $error("Green driven inside window");
    AST_CONN_COLOUR: assert property (@(posedge CLK) disable iff (!RESETN)
        LINK_STATE == MSC_ST_CONNECTED && !fl_ph_r |=> {GREEN_N, BLUE_N, RED_N} == 3'b101)
        else $error("Connected colour wrong");
    AST_FLASH_OFF: assert property (@(posedge CLK) disable iff (!RESETN)
        linked && fl_ph_r |=> {GREEN_N, BLUE_N, RED_N} == 3'b111)
        else $error("Flash phase not dark");
    AST_HW_REBOOT: assert property (@(posedge CLK) disable iff (!RESETN)
        !RESET_PIN_N_IN |-> ##3 HW_REBOOT || $past(RESET_PIN_N_IN, 3))
        else $error("Reset pin ignored");
    AST_SW_REBOOT: assert property (@(posedge CLK) disable iff (!RESETN)
        RESET_CMD |=> SW_REBOOT)
        else $error("Reset command ignored");
    AST_FACTORY: assert property (@(posedge CLK) disable iff (!RESETN)
        bs_r == MSC_BS_HOLD && both_low && ms_tick && ms_r == MS_W'(HOLD_MS - 1)
        |=> FACTORY_RESTORE && !LOADER_MODE)
        else $error("Factory restore missed");

endmodule : msc_status_io

//--- core/msc_sync_deb.sv
`timescale 1ns/1ns
module msc_sync_deb
    import msc_pkg::*;
#(
    parameter int unsigned STABLE_CYCLES = DEBOUNCE_CYCLES,
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pin_in,
    output logic level_out
);

    // ========================================
    // Two-stage synchroniser, first stage read only by second
    logic meta_r;
    logic sync_r;
    logic [TICK_W-1:0] cnt_r;
    logic [TICK_W-1:0] cnt_nxt;
    logic level_r;
    logic level_nxt;

    always_comb begin
        cnt_nxt = '0;
        level_nxt = level_r;
        if (sync_r != level_r) begin
            if (cnt_r == TICK_W'(STABLE_CYCLES - 1)) begin
                level_nxt = sync_r;
            end else begin
                cnt_nxt = cnt_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_r <= RESET_LEVEL;
            sync_r <= RESET_LEVEL;
            cnt_r <= '0;
            level_r <= RESET_LEVEL;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            cnt_r <= cnt_nxt;
            level_r <= level_nxt;
        end
    end

    assign level_out = level_r;

endmodule : msc_sync_deb

//--- testbench/msc_far_side.sv
`timescale 1ns/1ns
module msc_far_side #(
    parameter int SLEEP_HALF_NS = 15259
) (
    input wire logic press_connect,
    input wire logic press_serial,
    input wire logic pull_reset,
    input wire logic stop_sleep,
    input wire logic red_n,
    input wire logic green_n,
    input wire logic green_oe_n,
    input wire logic blue_n,
    output logic reset_pin_n,
    output logic connect_n,
    output logic serial_n,
    output logic sleep_clk,
    output logic [2:0] lit_gbr
);
    // ========================================
    // Pins
    // Only pulled low or let go; the pull-up does the rest
    assign reset_pin_n = pull_reset ? 1'h0 : 1'h1;
    assign connect_n = ~press_connect;
    // Shared pin: switch contact to ground beats the driver
    assign serial_n = (green_oe_n ? 1'h1 : green_n) & ~press_serial;
    assign lit_gbr = ~{serial_n, blue_n, red_n};
    // ========================================
    // Sleep clock
    // Runs free unless the bench takes the crystal away
    initial sleep_clk = 1'h0;
    always #SLEEP_HALF_NS sleep_clk = stop_sleep ? sleep_clk : ~sleep_clk;
endmodule : msc_far_side

//--- testbench/testbench.sv
`timescale 1ns/1ns
module testbench
    import msc_pkg::*;
;
    logic clk, resetn, dsr_n, cmd_mode, data_act, reset_cmd;
    logic dtr_gpio, dtr_val, dtr_ready, press_c, press_s, pull_rst;
    msc_link_e link;
    msc_dsr_e dsr_func;
    logic rst_pin_n, conn_n, ser_n, slp_clk;
    logic [2:0] lit;
    logic red_n, green_n, green_oe_n, blue_n, dtr_n, hw_reboot, sw_reboot;
    logic boot_done, ser_def, loader, factory, conn_req, d_cmd, d_disc, d_tgl;
    logic slp_ok, stop_slp;
    msc_boot_e action;
    int bad_count = 0;
    int num_checks = 0;

    // ========================================
    // Clock and parts
    initial clk = 1'h0;
    always #20 clk = ~clk;

    // Sleep clock edges well inside one shortened millisecond
    msc_far_side #(.SLEEP_HALF_NS(190)) fs (.press_connect(press_c), .press_serial(press_s),
        .pull_reset(pull_rst), .stop_sleep(stop_slp),
        .red_n(red_n), .green_n(green_n), .green_oe_n(green_oe_n), .blue_n(blue_n),
        .reset_pin_n(rst_pin_n), .connect_n(conn_n), .serial_n(ser_n),
        .sleep_clk(slp_clk), .lit_gbr(lit));

    // Short counts keep every boot under a few hundred cycles
    msc_status_io #(.MS_PERIOD(10), .BOOT_MS(5), .HOLD_MS(20), .FLASH_PERIOD_MS(2),
        .DEB_CYCLES(3)) dut (.CLK(clk), .RESETN(resetn), .RESET_PIN_N_IN(rst_pin_n),
        .SWITCH_CONNECT_N(conn_n), .SWITCH_SERIAL_N(ser_n), .DSR_N(dsr_n),
        .SLOW_SLEEP_CLOCK_IN(slp_clk), .CMD_MODE(cmd_mode), .LINK_STATE(link),
        .DATA_ACTIVITY(data_act), .RESET_CMD(reset_cmd), .DSR_FUNC(dsr_func),
        .DTR_AS_GPIO(dtr_gpio), .DTR_GPIO_VALUE(dtr_val), .DTR_READY(dtr_ready),
        .RED_N(red_n), .GREEN_N(green_n), .GREEN_OE_N(green_oe_n), .BLUE_N(blue_n),
        .DTR_N(dtr_n), .HW_REBOOT(hw_reboot), .SW_REBOOT(sw_reboot),
        .BOOT_DONE(boot_done), .BOOT_ACTION(action), .SERIAL_DEFAULTS(ser_def),
        .LOADER_MODE(loader), .FACTORY_RESTORE(factory), .CONNECT_REQ(conn_req),
        .DSR_CMD_REQ(d_cmd), .DSR_DISC_REQ(d_disc), .DSR_CONNTGL_REQ(d_tgl),
        .SLEEP_CLK_PRESENT(slp_ok));

    // ========================================
    // Helpers
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Sample just after the edge so its updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic restart(input logic c, input logic s);
        @(posedge clk);
        resetn <= 1'h0;
        press_c <= c;
        press_s <= s;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
    endtask : restart

    task automatic wait_boot();
        for (int i = 0; i < 400 && boot_done !== 1'h1; i++) cyc(1);
        check("boot_done", boot_done, 4'h1);
    endtask : wait_boot

    task automatic release_sw();
        @(posedge clk);
        press_c <= 1'h0;
        press_s <= 1'h0;
    endtask : release_sw

    // ========================================
    // Scenarios
    task automatic t_boot_plain();
        for (int k = 0; k < 3; k++) begin
            restart(k[0], k[1]);
            cyc(20);
            check("green_oe_early", green_oe_n, 4'h1);
            wait_boot();
            check("action", action, k[1] ? MSC_BOOT_SERIAL_DEF : MSC_BOOT_NORMAL);
            check("serial_def", ser_def, {3'h0, k[1]});
            release_sw();
        end
        // Late presses must not reopen the choice
        @(posedge clk);
        press_c <= 1'h1;
        press_s <= 1'h1;
        cyc(300);
        check("late_action", action, MSC_BOOT_SERIAL_DEF);
        check("late_loader", loader, 4'h0);
        check("late_serdef", ser_def, 4'h1);
        release_sw();
    endtask : t_boot_plain

    task automatic t_loader();
        restart(1'h1, 1'h1);
        for (int i = 0; i < 300 && loader !== 1'h1; i++) cyc(1);
        check("loader", loader, 4'h1);
        check("loader_oe", green_oe_n, 4'h1);
        // Serial switch let go alone must still be seen on the shared pin
        @(posedge clk);
        press_s <= 1'h0;
        wait_boot();
        check("loader_action", action, MSC_BOOT_LOADER);
        check("no_factory", factory, 4'h0);
        release_sw();
    endtask : t_loader

    task automatic t_factory();
        restart(1'h1, 1'h1);
        cyc(150);
        check("hold_early", boot_done, 4'h0);
        wait_boot();
        check("factory_action", action, MSC_BOOT_FACTORY);
        check("factory", factory, 4'h1);
        release_sw();
    endtask : t_factory

    task automatic t_colours();
        logic [2:0] exp;
        restart(1'h0, 1'h0);
        wait_boot();
        cyc(1);
        check("green_oe", green_oe_n, 4'h0);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            cmd_mode <= i[0];
            link <= msc_link_e'(i / 2);
            exp = (i < 2) ? (i[0] ? 3'h2 : 3'h3) : ((i < 4) ? 3'h4 : 3'h5);
            cyc(4);
            check("gbr", {1'h0, green_n, blue_n, red_n}, {1'h0, exp});
            check("lit", {1'h0, lit}, {1'h0, ~exp});
        end
    endtask : t_colours

    task automatic t_flash();
        int dark;
        dark = 0;
        for (int i = 0; i < 60; i++) begin
            cyc(1);
            dark += int'(blue_n);
        end
        check("steady", {3'h0, dark > 0}, 4'h0);
        @(posedge clk);
        data_act <= 1'h1;
        for (int i = 0; i < 100; i++) begin
            cyc(1);
            dark += int'(blue_n);
        end
        check("flash", {3'h0, dark > 0}, 4'h1);
        @(posedge clk);
        data_act <= 1'h0;
    endtask : t_flash

    task automatic t_connect();
        @(posedge clk);
        press_c <= 1'h1;
        cyc(12);
        check("connect_on", conn_req, 4'h1);
        release_sw();
        cyc(12);
        check("connect_off", conn_req, 4'h0);
    endtask : t_connect

    task automatic t_dsr();
        logic [3:0] nc, nd, nt;
        for (int f = 0; f < 4; f++) begin
            nc = 4'h0;
            nd = 4'h0;
            nt = 4'h0;
            @(posedge clk);
            dsr_func <= msc_dsr_e'(f);
            dsr_n <= 1'h0;
            for (int i = 0; i < 20; i++) begin
                cyc(1);
                nc += {3'h0, d_cmd};
                nd += {3'h0, d_disc};
                nt += {3'h0, d_tgl};
            end
            check("dsr_cmd", nc, {3'h0, f == 1});
            check("dsr_disc", nd, {3'h0, f == 2});
            check("dsr_tgl", nt, {3'h0, f == 3});
            @(posedge clk);
            dsr_n <= 1'h1;
            cyc(12);
        end
    endtask : t_dsr

    task automatic t_dtr();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            dtr_gpio <= i[1];
            dtr_val <= i[0];
            dtr_ready <= i[0];
            cyc(4);
            check("dtr", {3'h0, dtr_n}, {3'h0, i[1] ? i[0] : ~i[0]});
        end
    endtask : t_dtr

    task automatic t_reboot();
        @(posedge clk);
        reset_cmd <= 1'h1;
        @(posedge clk);
        reset_cmd <= 1'h0;
        #1;
        check("sw_reboot", sw_reboot, 4'h1);
        cyc(1);
        check("sw_reboot_end", sw_reboot, 4'h0);
        @(posedge clk);
        pull_rst <= 1'h1;
        cyc(5);
        check("hw_reboot", hw_reboot, 4'h1);
        @(posedge clk);
        pull_rst <= 1'h0;
        cyc(5);
        check("hw_reboot_end", hw_reboot, 4'h0);
    endtask : t_reboot

    task automatic t_sleep();
        cyc(40);
        check("sleep_on", {3'h0, slp_ok}, 4'h1);
        @(posedge clk);
        stop_slp <= 1'h1;
        cyc(60);
        check("sleep_off", {3'h0, slp_ok}, 4'h0);
        @(posedge clk);
        stop_slp <= 1'h0;
        cyc(40);
        check("sleep_back", {3'h0, slp_ok}, 4'h1);
    endtask : t_sleep

    // ========================================
    // Verdict and run
    task automatic results();
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        results();
    end

    initial begin
        {resetn, cmd_mode, data_act, reset_cmd, dtr_gpio, dtr_val} = 6'h0;
        {dtr_ready, press_c, press_s, pull_rst} = 4'h0;
        dsr_n = 1'h1;
        stop_slp = 1'h0;
        link = MSC_ST_IDLE;
        dsr_func = MSC_DSR_OFF;
        t_boot_plain();
        t_loader();
        t_factory();
        t_colours();
        t_flash();
        t_connect();
        t_dsr();
        t_dtr();
        t_sleep();
        t_reboot();
        results();
    end
endmodule : testbench
